// *** asp_regs.vh ***
`ifndef ASP_REGS_VH
`define ASP_REGS_VH
// System clock rate in Hz
`define ASP_CLK_HZ 25000000
// Oversampling factor of the receiver
`define ASP_OVS 16
// Baud select codes, slowest first
`define ASP_BAUD_300 3'h0
`define ASP_BAUD_600 3'h1
`define ASP_BAUD_1200 3'h2
`define ASP_BAUD_2400 3'h3
`define ASP_BAUD_4800 3'h4
`define ASP_BAUD_9600 3'h5
`define ASP_BAUD_19200 3'h6
// Bit periods per second for each code
`define ASP_RATE_300 300
`define ASP_RATE_600 600
`define ASP_RATE_1200 1200
`define ASP_RATE_2400 2400
`define ASP_RATE_4800 4800
`define ASP_RATE_9600 9600
`define ASP_RATE_19200 19200
// Frame layout
`define ASP_DATA_BITS 8
`define ASP_STOP_BITS 2
// Line levels
`define ASP_LVL_START 1'h0
`define ASP_LVL_STOP 1'h1
`endif

// *** asp_tick_gen.v ***
`timescale 1ns/1ns
`default_nettype none
`include "asp_regs.vh"
// Oversample tick: pulses OVS times per bit at the selected rate
module asp_tick_gen (
  input wire clk,
  input wire rst,
  input wire [2:0] baud_sel,
  output reg tick
);
  reg [15:0] cnt_reg;
  reg [15:0] limit;

  // Divide ratio per rate, rounded down so the top rate stays close
  function [15:0] div_of;
    input [2:0] sel;
    integer rate;
    integer ratio;
    begin
      case (sel)
        `ASP_BAUD_300: rate = `ASP_RATE_300;
        `ASP_BAUD_600: rate = `ASP_RATE_600;
        `ASP_BAUD_1200: rate = `ASP_RATE_1200;
        `ASP_BAUD_2400: rate = `ASP_RATE_2400;
        `ASP_BAUD_4800: rate = `ASP_RATE_4800;
        `ASP_BAUD_9600: rate = `ASP_RATE_9600;
        default: rate = `ASP_RATE_19200;
      endcase
      // Ratio fits 16 bits even at the slowest rate
      ratio = `ASP_CLK_HZ / (rate * `ASP_OVS);
      div_of = ratio[15:0];
    end
  endfunction

  always @*
  begin
    limit = div_of(baud_sel) - 16'h0001;
  end

  // Free running divider
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt_reg >= limit)
    begin
      cnt_reg <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // asp_tick_gen
`default_nettype wire

// *** asp_port.v ***
`timescale 1ns/1ns
`default_nettype none
`include "asp_regs.vh"
module asp_port (
  input wire clk,
  input wire rst,
  input wire [2:0] baud_sel,
  input wire parity_en,
  input wire parity_odd,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output reg tx_ready,
  output reg [7:0] rx_data,
  output reg rx_valid,
  input wire dtr_pin,
  input wire dtr_connected,
  input wire rxd_pin,
  output reg txd_pin,
  output reg cts_pin
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SEND = 2'h1;
  localparam RS_IDLE = 2'h0;
  localparam RS_START = 2'h1;
  localparam RS_DATA = 2'h2;
  localparam RS_STOP = 2'h3;

  wire tick;
  reg dtr_meta_reg, dtr_sync_reg, rxd_meta_reg, rxd_sync_reg;
  reg con_meta_reg, con_sync_reg;
  reg [1:0] tx_state_reg;
  reg [10:0] tx_shift_reg;
  reg [3:0] tx_left_reg;
  reg [3:0] tx_os_reg;
  reg [1:0] rx_state_reg;
  reg [3:0] rx_os_reg;
  reg [3:0] rx_cnt_reg;
  reg [7:0] rx_shift_reg;
  wire host_ready;
  wire par_bit;

  asp_tick_gen u_tick (
    .clk(clk),
    .rst(rst),
    .baud_sel(baud_sel),
    .tick(tick)
  );

  // Pins come from another domain, two stages each
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dtr_meta_reg <= 1'b1;
      dtr_sync_reg <= 1'b1;
      con_meta_reg <= 1'b0;
      con_sync_reg <= 1'b0;
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end
    else
    begin
      dtr_meta_reg <= dtr_pin;
      dtr_sync_reg <= dtr_meta_reg;
      con_meta_reg <= dtr_connected;
      con_sync_reg <= con_meta_reg;
      rxd_meta_reg <= rxd_pin;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // absent handshake line counts as ready
  // DTR gates the start of a character
  assign host_ready = dtr_sync_reg | ~con_sync_reg;

  // parity only generated, even unless odd chosen
  assign par_bit = (^tx_data) ^ parity_odd;

  // Transmitter; a frame in flight always completes, DTR only holds
  // off the next one so the host never sees a cut character
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state_reg <= ST_IDLE;
      tx_shift_reg <= 11'h7FF;
      tx_left_reg <= 4'h0;
      tx_os_reg <= 4'h0;
      tx_ready <= 1'b0;
      txd_pin <= `ASP_LVL_STOP;
    end
    else
    begin
      case (tx_state_reg)
        ST_IDLE:
        begin
          txd_pin <= `ASP_LVL_STOP;
          tx_ready <= host_ready;
          // ready follows host, so a take honours DTR
          // Take on valid and ready alone so the offer is never lost
          if (tx_valid && tx_ready)
          begin
            tx_ready <= 1'b0;
            tx_os_reg <= 4'h0;
            tx_state_reg <= ST_SEND;
            if (parity_en)
            begin
              tx_shift_reg <= {`ASP_LVL_STOP, par_bit, tx_data,
                               `ASP_LVL_START};
              tx_left_reg <= 4'hC;
            end
            else
            begin
              tx_shift_reg <= {`ASP_LVL_STOP, `ASP_LVL_STOP, tx_data,
                               `ASP_LVL_START};
              tx_left_reg <= 4'hB;
            end
          end
        end
        default:
        begin
          txd_pin <= tx_shift_reg[0];
          if (tick)
          begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == 4'hF)
            begin
              // shift right, LSB first
              // With parity on, a one shifted in supplies the final stop bit
              tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
              tx_left_reg <= tx_left_reg - 4'h1;
              if (tx_left_reg == 4'h1)
                tx_state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Receiver
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_state_reg <= RS_IDLE;
      rx_os_reg <= 4'h0;
      rx_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      cts_pin <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      cts_pin <= (rx_state_reg == RS_IDLE);
      case (rx_state_reg)
        RS_IDLE:
        begin
          if (rxd_sync_reg == `ASP_LVL_START)
          begin
            rx_os_reg <= 4'h0;
            rx_state_reg <= RS_START;
          end
        end
        RS_START:
        begin
          if (tick)
          begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == 4'h7)
            begin
              // glitch rejected at mid start bit
              if (rxd_sync_reg == `ASP_LVL_START)
              begin
                rx_os_reg <= 4'h0;
                rx_cnt_reg <= 4'h0;
                rx_state_reg <= RS_DATA;
              end
              else
                rx_state_reg <= RS_IDLE;
            end
          end
        end
        RS_DATA:
        begin
          if (tick)
          begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == 4'hF)
            begin
              // parity slot is passed over, never compared
              if (rx_cnt_reg != 4'h8)
                rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[7:1]};
              rx_cnt_reg <= rx_cnt_reg + 4'h1;
              // A low parity bit must not look like a fresh start
              if (rx_cnt_reg == (parity_en ? 4'h8 : 4'h7))
                rx_state_reg <= RS_STOP;
            end
          end
        end
        default:
        begin
          // no parity or framing check; wait for idle level
          if (rxd_sync_reg == `ASP_LVL_STOP)
          begin
            rx_data <= rx_shift_reg;
            rx_valid <= 1'b1;
            rx_state_reg <= RS_IDLE;
          end
        end
      endcase
    end
  end
endmodule // asp_port
`default_nettype wire

// *** asp_port_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module asp_port_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] baud_sel,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic dtr_pin,
  input wire logic dtr_connected,
  input wire logic rxd_pin,
  input wire logic txd_pin,
  input wire logic cts_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles from a take to the end of its start bit, top rate only
  logic bt_on, bt_txd_q;
  logic [11:0] bt_cnt;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bt_on <= 1'b0;
      bt_txd_q <= 1'b1;
      bt_cnt <= 12'h000;
    end
    else
    begin
      bt_txd_q <= txd_pin;
      if (tx_valid && tx_ready && tx_data[0] && baud_sel[2:1] == 2'h3)
      begin
        bt_on <= 1'b1;
        bt_cnt <= 12'h001;
      end
      else if (bt_on)
      begin
        bt_cnt <= bt_cnt + 12'h001;
        // First rise ends the measurement
        if (txd_pin && !bt_txd_q)
          bt_on <= 1'b0;
      end
    end
  end
  // Take, then ready drops and the start bit follows
  sequence tx_take;
    tx_valid && tx_ready;
  endsequence
  sequence tx_launch;
    !tx_ready ##1 !txd_pin;
  endsequence
  AST_TX_START: assert property (tx_take |=> tx_launch)
    else $error("no start bit");
  AST_BIT_TIME: assert property (bt_on && $rose(txd_pin)
    |-> bt_cnt >= 12'h4BA && bt_cnt <= 12'h514)
    else $error("bit time off");
  AST_DTR_HOLD: assert property ((dtr_connected && !dtr_pin) [*5]
    |-> !tx_ready) else $error("sent unready");
  AST_IDLE_HIGH: assert property (tx_ready |-> txd_pin)
    else $error("idle low");
  AST_CTS_DROP: assert property ($fell(rxd_pin) && cts_pin
    |-> ##[1:5] !cts_pin) else $error("cts high");
  AST_CTS_BACK: assert property (rx_valid |=> cts_pin)
    else $error("cts low");
  AST_RX_HELD: assert property (!$stable(rx_data) |-> rx_valid)
    else $error("rx data moved");
  AST_RX_STOP: assert property (rx_valid
    |-> rxd_pin && $past(rxd_pin, 2)) else $error("early byte");
endmodule // asp_port_chk
bind asp_port asp_port_chk chk_u (.clk(clk), .rst(rst), .baud_sel(baud_sel),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_data(rx_data), .rx_valid(rx_valid), .dtr_pin(dtr_pin),
  .dtr_connected(dtr_connected), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
  .cts_pin(cts_pin));
`default_nettype wire

// *** asp_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module asp_host (
  input wire logic txd_pin,
  output logic rxd_pin,
  output logic dtr_pin
);
  localparam int BIT_NS = 51840;
  logic [10:0] frame_reg;
  int frame_cnt_reg = 0;
  // not ready at first; line idles at stop level
  initial
  begin
    rxd_pin = 1'h1;
    dtr_pin = 1'h0;
  end
  // slot centres; stops early so a back-to-back start is seen
  always @(negedge txd_pin)
  begin
    #(BIT_NS / 2);
    for (int i = 0; i < 11; i++)
    begin
      frame_reg[i] = txd_pin;
      #((i < 10) ? BIT_NS : 0);
    end
    frame_cnt_reg++;
  end
  // host raises DTR once it can take data
  task automatic set_dtr(input logic v);
    dtr_pin = v;
  endtask
  // same framing out: start, LSB first, parity slot, stops
  task automatic send(input logic [7:0] d, input logic par);
    logic [11:0] f;
    f = {2'h3, par, d, 1'h0};
    for (int i = 0; i < 12; i++)
    begin
      rxd_pin = f[i];
      #(BIT_NS);
    end
  endtask
endmodule // asp_host
`default_nettype wire

// *** async_serial_port_dtr_flow_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module async_serial_port_dtr_flow_bench;
  logic clk, rst, parity_en, parity_odd, tx_valid, dtr_connected;
  logic [2:0] baud_sel;
  logic [7:0] tx_data;
  wire logic [7:0] rx_data;
  wire logic tx_ready, rx_valid, dtr_pin, rxd_pin, txd_pin, cts_pin;
  int failures = 0;
  int checks = 0;
  asp_port dut_u (.clk(clk), .rst(rst), .baud_sel(baud_sel),
    .parity_en(parity_en), .parity_odd(parity_odd), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .dtr_pin(dtr_pin), .dtr_connected(dtr_connected),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .cts_pin(cts_pin));
  asp_host host_u (.txd_pin(txd_pin), .rxd_pin(rxd_pin), .dtr_pin(dtr_pin));
  // Free-running 25 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Offer a byte once idle, then read its frame off the wire
  task automatic t_tx(input logic [7:0] d, input logic pe, input logic po);
    int k;
    while (tx_ready !== 1'h1) @(posedge clk) #1;
    {parity_en, parity_odd, tx_data, tx_valid} = {pe, po, d, 1'h1};
    k = host_u.frame_cnt_reg;
    @(posedge clk) #1;
    tx_valid = 1'h0;
    while (host_u.frame_cnt_reg == k) @(posedge clk);
    chk(host_u.frame_reg, {1'h1, pe ? ^d ^ po : 1'h1, d, 1'h0});
  endtask
  // Strapped DTR low stalls sending until the host raises it
  task automatic t_dtr;
    #1;
    dtr_connected = 1'h1;
    fork
      t_tx(8'h5A, 1'h0, 1'h0);
      begin
        repeat (4000) @(posedge clk);
        #1;
        chk(tx_ready, 1'h0);
        chk(txd_pin, 1'h1);
        host_u.set_dtr(1'h1);
      end
    join
  endtask
  // Host frames in; a wrong parity slot is still accepted
  task automatic t_rx(input logic [7:0] d, input logic par);
    fork
      host_u.send(d, par);
      begin
        while (rx_valid !== 1'h1) @(posedge clk) #1;
        chk(rx_data, d);
        chk(cts_pin, 1'h0);
        @(posedge clk) #1;
        chk(cts_pin, 1'h1);
      end
    join
  endtask
  // Main sequence; host DTR is low but unstrapped at first
  initial
  begin
    {rst, baud_sel, parity_en, parity_odd} = {1'h1, 3'h6, 2'h0};
    {tx_data, tx_valid, dtr_connected} = 10'h000;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'h0;
    t_tx(8'h41, 1'h0, 1'h0);
    t_tx(8'h07, 1'h1, 1'h1);
    t_dtr;
    #1;
    parity_en = 1'h1;
    t_rx(8'hB6, 1'h0);
    t_rx(8'h6D, 1'h1);
    end_of_test;
  end
  // Watchdog: five frames at the top rate fit well inside this
  initial
  begin
    #3800000;
    failures++;
    end_of_test;
  end
endmodule // async_serial_port_dtr_flow_bench
`default_nettype wire
